// ### rdls_chk.sv
`timescale 1ns/1ps
// watches link outputs of the redriver control block
module rdls_chk #(
    parameter int PG_CYCLES = 20000
) (
    // clock and reset
    input wire logic       mclk,
    input wire logic       srst,
    // link sensing
    input wire logic       ufp_elec_idle,
    input wire logic       dfp_elec_idle,
    input wire logic       lfps_det,
    // link control
    input wire logic       power_good,
    input wire logic       strap_bias_en,
    input wire logic       rx_detect_req,
    input wire logic       redrive_en,
    input wire logic       rx_term_en,
    input wire logic       tx_cm_en,
    input wire logic [3:0] dfp_eq_out,
    input wire logic [3:0] ufp_eq_out,
    input wire logic [3:0] link_state
);
    int pg_cnt;      // cycles since reset release, saturating
    int next_pg_cnt; // next count
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // count up from reset release, stop past the power-good limit
    always_comb begin
        next_pg_cnt = srst ? 0 : ((pg_cnt < PG_CYCLES + 8) ? pg_cnt + 1 : pg_cnt);
    end
    // register the count
    always_ff @(posedge mclk) begin
        pg_cnt <= next_pg_cnt;
    end
    property p_disc_exit;
        (link_state == 4'h1) ##1 (link_state != 4'h1) |-> link_state == 4'h2;
    endproperty
    a_disc_exit: assert property (p_disc_exit) else $error("disconnect left to other state");
    property p_u0_idle;
        (link_state == 4'h2 && ufp_elec_idle && dfp_elec_idle) [*4] |=> link_state != 4'h2;
    endproperty
    a_u0_idle: assert property (p_u0_idle) else $error("stayed in U0 while idle");
    property p_redrive;
        redrive_en == (link_state == 4'h2);
    endproperty
    a_redrive: assert property (p_redrive) else $error("redrive not tied to U0");
    property p_term;
        rx_term_en == (link_state != 4'h1);
    endproperty
    a_term: assert property (p_term) else $error("termination wrong for state");
    property p_txcm;
        tx_cm_en == (link_state == 4'h2 || link_state == 4'h4);
    endproperty
    a_txcm: assert property (p_txcm) else $error("common mode wrong for state");
    property p_lfps_wake;
        $rose(lfps_det) && link_state == 4'h8 |-> ##[1:4] link_state == 4'h2;
    endproperty
    a_lfps_wake: assert property (p_lfps_wake) else $error("no wake from U2/U3");
    property p_rxdet;
        rx_detect_req |-> (link_state == 4'h1 || link_state == 4'h8);
    endproperty
    a_rxdet: assert property (p_rxdet) else $error("detection outside low states");
    property p_eq_lfps;
        lfps_det [*4] |-> (dfp_eq_out == 4'h0 && ufp_eq_out == 4'h0);
    endproperty
    a_eq_lfps: assert property (p_eq_lfps) else $error("eq left on during lfps");
    property p_pg;
        !power_good |-> pg_cnt <= PG_CYCLES + 3;
    endproperty
    a_pg: assert property (p_pg) else $error("power good late");
    property p_bias;
        !strap_bias_en |-> power_good;
    endproperty
    a_bias: assert property (p_bias) else $error("bias dropped before power good");
endmodule

bind rdls_top rdls_chk #(.PG_CYCLES(PG_CYCLES)) i_rdls_chk (.*);

// ### rdls_debounce.sv
`timescale 1ns/1ps
// synchronises a pin and accepts a new level after it holds steady
module rdls_debounce #(
    parameter int COUNT = 640000
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // pin and filtered level
    input  wire logic pin,
    input  wire logic init_level,
    output logic      level
);
    initial begin
        if (COUNT < 1) $error("debounce count must be positive");
    end
    logic        sync1;             // first stage, read only by sync2
    logic        sync2;             // synchronised pin
    logic [31:0] cnt;               // stability counter
    logic [31:0] next_cnt;
    logic        next_level;

    // count while synchronised pin differs from accepted level
    always_comb begin
        next_cnt   = 32'h0000_0000;
        next_level = level;
        if (sync2 != level) begin
            if (cnt >= 32'(COUNT - 1)) begin
                next_level = sync2;
            end else begin
                next_cnt = cnt + 32'h0000_0001;
            end
        end
    end

    // registers
    always_ff @(posedge mclk) begin
        sync1 <= pin;
        sync2 <= sync1;
        if (srst) begin
            cnt   <= 32'h0000_0000;
            level <= init_level;
        end else begin
            cnt   <= next_cnt;
            level <= next_level;
        end
    end
endmodule

// ### rdls_link_partner.sv
`timescale 1ns/1ps
// far-end ports: terminations change only at a detection pulse
module rdls_link_partner (
    // clock
    input wire logic mclk,
    // scenario commands
    input wire logic attached,
    input wire logic idle_cmd,
    input wire logic lfps_cmd,
    // block side
    input wire logic rx_detect_req,
    output logic     ufp_term_det,
    output logic     dfp_term_det,
    output logic     ufp_elec_idle,
    output logic     dfp_elec_idle,
    output logic     lfps_det
);
    logic det_seen = 1'b0; // result of the last detection pulse
    // a detection pulse samples whether a receiver is present
    always_ff @(posedge mclk) begin
        if (rx_detect_req) begin
            det_seen <= attached;
        end
    end
    // both ports answer alike; idle and lfps follow the scenario
    assign ufp_term_det  = det_seen;
    assign dfp_term_det  = det_seen;
    assign ufp_elec_idle = idle_cmd;
    assign dfp_elec_idle = idle_cmd;
    assign lfps_det      = lfps_cmd;
endmodule

// ### rdls_pkg.sv
package rdls_pkg;
    // link power states, one-hot
    typedef enum logic [3:0] {
        RDLS_DISC = 4'h1,
        RDLS_U0   = 4'h2,
        RDLS_U1   = 4'h4,
        RDLS_U23  = 4'h8
    } rdls_state_e;
    // four-level pin rank 0, R, F, 1
    typedef logic [1:0] rdls_level_t;
endpackage

// ### rdls_regs.svh
`ifndef RDLS_REGS_SVH
`define RDLS_REGS_SVH
// register byte offsets
`define RDLS_GENERAL_OFFSET    8'h28
`define RDLS_EQ_OFFSET         8'h2C
`define RDLS_STATUS_OFFSET     8'h30
`define RDLS_U2_IDLE_OFFSET    8'h34
// general register fields
`define RDLS_CFG_LO_BIT        0
`define RDLS_CFG_HI_BIT        1
`define RDLS_FLIP_BIT          2
// eq register fields
`define RDLS_DFP1_EQ_LSB       0
`define RDLS_DFP2_EQ_LSB       4
`define RDLS_UFP_EQ_LSB        8
// reset values
`define RDLS_GENERAL_RESET     32'h0000_0001
`define RDLS_EQ_RESET          32'h0000_0000
`define RDLS_U2_IDLE_RESET     32'h0000_1000
// timing (ns) at 25 ns period
`define RDLS_CLK_PERIOD_NS     25
`define RDLS_PG_DELAY_NS       500000
`define RDLS_CFG_HOLD_NS       10000
`define RDLS_DEBOUNCE_NS       16000000
`endif

// ### rdls_top.sv
`timescale 1ns/1ps
`include "rdls_regs.svh"
module rdls_top #(
    parameter int PG_CYCLES  = (`RDLS_PG_DELAY_NS / `RDLS_CLK_PERIOD_NS),
    parameter int HD_CYCLES  = ((`RDLS_CFG_HOLD_NS + `RDLS_CLK_PERIOD_NS - 1)
                                / `RDLS_CLK_PERIOD_NS),
    parameter int DB_CYCLES  = (`RDLS_DEBOUNCE_NS / `RDLS_CLK_PERIOD_NS),
    parameter int RX_PERIOD  = 4096
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // straps and pins
    input  wire logic [1:0]  mode_strap,
    input  wire logic [3:0]  dfp_eq_inputs,
    input  wire logic [3:0]  ufp_eq_inputs,
    input  wire logic        superspeed_enable_pin,
    input  wire logic        orientation_pin,
    input  wire logic        test_strap,
    // link sensing
    input  wire logic        ufp_term_det,
    input  wire logic        dfp_term_det,
    input  wire logic        ufp_elec_idle,
    input  wire logic        dfp_elec_idle,
    input  wire logic        lfps_det,
    // link control
    output logic             power_good,
    output logic             strap_bias_en,
    output logic             rx_detect_req,
    output logic             redrive_en,
    output logic             rx_term_en,
    output logic             tx_cm_en,
    output logic             flip_en,
    output logic [3:0]       dfp_eq_out,
    output logic [3:0]       ufp_eq_out,
    output logic [3:0]       link_state,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    initial begin
        if (PG_CYCLES < 1 || HD_CYCLES < 1 || DB_CYCLES < 1 || RX_PERIOD < 2)
            $error("timing counts out of range");
    end

    // eq index from two four-level ranks
    function automatic logic [3:0] eq_index(input rdls_pkg::rdls_level_t hi,
                                            input rdls_pkg::rdls_level_t lo);
        eq_index = {hi, lo};
    endfunction

    // two-flop synchronisers for pins
    logic [1:0]  mode_s1, mode_s2;
    logic [3:0]  dfp_s1, dfp_s2, ufp_s1, ufp_s2;
    logic [4:0]  link_s1, link_s2;  // ufp term, dfp term, ufp idle, dfp idle, lfps
    always_ff @(posedge mclk) begin
        mode_s1 <= mode_strap;
        mode_s2 <= mode_s1;
        dfp_s1  <= dfp_eq_inputs;
        dfp_s2  <= dfp_s1;
        ufp_s1  <= ufp_eq_inputs;
        ufp_s2  <= ufp_s1;
        link_s1 <= {ufp_term_det, dfp_term_det, ufp_elec_idle, dfp_elec_idle, lfps_det};
        link_s2 <= link_s1;
    end
    logic both_term, both_idle, lfps;
    assign both_term = link_s2[4] & link_s2[3];
    assign both_idle = link_s2[2] & link_s2[1];
    assign lfps      = link_s2[0];

    // debounced enable, orientation and test pins
    logic en_db, flip_db, test_db;
    rdls_debounce #(.COUNT(DB_CYCLES)) u_db_en (
        .mclk(mclk), .srst(srst), .pin(superspeed_enable_pin),
        .init_level(1'b0), .level(en_db));
    rdls_debounce #(.COUNT(DB_CYCLES)) u_db_flip (
        .mclk(mclk), .srst(srst), .pin(orientation_pin),
        .init_level(1'b0), .level(flip_db));
    rdls_debounce #(.COUNT(DB_CYCLES)) u_db_test (
        .mclk(mclk), .srst(srst), .pin(test_strap),
        .init_level(1'b0), .level(test_db));

    // power-good timer, strap latch and bias hold
    logic [31:0] pg_cnt, next_pg_cnt;
    logic [31:0] hd_cnt, next_hd_cnt;
    logic        next_power_good, next_bias;
    logic        reg_mode, next_reg_mode;
    logic [3:0]  dfp_lat, next_dfp_lat, ufp_lat, next_ufp_lat;
    always_comb begin
        next_pg_cnt     = pg_cnt;
        next_hd_cnt     = hd_cnt;
        next_power_good = power_good;
        next_bias       = strap_bias_en;
        next_reg_mode   = reg_mode;
        next_dfp_lat    = dfp_lat;
        next_ufp_lat    = ufp_lat;
        if (!power_good) begin
            // power good asserts after the delay
            if (pg_cnt >= 32'(PG_CYCLES - 1)) begin
                next_power_good = 1'b1;
                next_reg_mode   = (mode_s2 != 2'b00);
                next_dfp_lat    = dfp_s2;
                next_ufp_lat    = ufp_s2;
            end else begin
                next_pg_cnt = pg_cnt + 32'h0000_0001;
            end
        end else if (strap_bias_en) begin
            // isolate strap bias after the hold time
            if (hd_cnt >= 32'(HD_CYCLES - 1)) begin
                next_bias = 1'b0;
            end else begin
                next_hd_cnt = hd_cnt + 32'h0000_0001;
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            pg_cnt        <= 32'h0000_0000;
            hd_cnt        <= 32'h0000_0000;
            power_good    <= 1'b0;
            strap_bias_en <= 1'b1;
            reg_mode      <= 1'b0;
            dfp_lat       <= 4'h0;
            ufp_lat       <= 4'h0;
        end else begin
            pg_cnt        <= next_pg_cnt;
            hd_cnt        <= next_hd_cnt;
            power_good    <= next_power_good;
            strap_bias_en <= next_bias;
            reg_mode      <= next_reg_mode;
            dfp_lat       <= next_dfp_lat;
            ufp_lat       <= next_ufp_lat;
        end
    end

    // pin-mode enable: on after power-up, off after low-high-low sequence
    logic pin_en, next_pin_en, en_seen_hi, next_en_seen_hi, en_prev;
    always_comb begin
        next_pin_en     = pin_en;
        next_en_seen_hi = en_seen_hi;
        if (en_db && !en_prev) begin
            next_en_seen_hi = 1'b1;
            next_pin_en     = 1'b1;
        end else if (!en_db && en_prev && en_seen_hi) begin
            next_pin_en = 1'b0;
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_en     <= 1'b1;
            en_seen_hi <= 1'b0;
            en_prev    <= 1'b0;
        end else begin
            pin_en     <= next_pin_en;
            en_seen_hi <= next_en_seen_hi;
            en_prev    <= en_db;
        end
    end

    // software registers
    logic [31:0] gen_reg, eq_reg, idle_reg;
    logic        cfg_on, cfg_flip;
    // config 01 is one port, everything else powers down
    assign cfg_on   = reg_mode ? (gen_reg[1:0] == 2'b01) : pin_en;
    assign cfg_flip = reg_mode ? gen_reg[`RDLS_FLIP_BIT] : flip_db;

    // link power-state machine
    rdls_pkg::rdls_state_e state, next_state;
    logic [31:0] idle_cnt, next_idle_cnt;
    logic [31:0] rx_cnt, next_rx_cnt;
    always_comb begin
        next_state    = state;
        next_idle_cnt = 32'h0000_0000;
        next_rx_cnt   = 32'h0000_0000;
        if (!cfg_on || !power_good || test_db) begin
            next_state = rdls_pkg::RDLS_DISC;
        end else begin
            case (state)
                rdls_pkg::RDLS_DISC: begin
                    next_rx_cnt = (rx_cnt >= 32'(RX_PERIOD - 1)) ? 32'h0 : rx_cnt + 32'h1;
                    if (both_term) next_state = rdls_pkg::RDLS_U0;
                end
                rdls_pkg::RDLS_U0: begin
                    if (both_idle) next_state = rdls_pkg::RDLS_U1;
                end
                rdls_pkg::RDLS_U1: begin
                    if (lfps || !both_idle) begin
                        next_state = rdls_pkg::RDLS_U0;
                    end else if (idle_cnt >= idle_reg) begin
                        next_state = rdls_pkg::RDLS_U23;
                    end else begin
                        next_idle_cnt = idle_cnt + 32'h0000_0001;
                    end
                end
                rdls_pkg::RDLS_U23: begin
                    next_rx_cnt = (rx_cnt >= 32'(RX_PERIOD - 1)) ? 32'h0 : rx_cnt + 32'h1;
                    if (lfps) next_state = rdls_pkg::RDLS_U0;
                    else if (rx_cnt == 32'h0000_0002 && !both_term)
                        next_state = rdls_pkg::RDLS_DISC;
                end
                default: next_state = rdls_pkg::RDLS_DISC;
            endcase
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            state    <= rdls_pkg::RDLS_DISC;
            idle_cnt <= 32'h0000_0000;
            rx_cnt   <= 32'h0000_0000;
        end else begin
            state    <= next_state;
            idle_cnt <= next_idle_cnt;
            rx_cnt   <= next_rx_cnt;
        end
    end

    // link control outputs
    logic [3:0] dfp_sel, ufp_sel;
    always_comb begin
        dfp_sel = reg_mode ? (cfg_flip ? eq_reg[7:4] : eq_reg[3:0])
                           : eq_index(dfp_lat[3:2], dfp_lat[1:0]);
        ufp_sel = reg_mode ? eq_reg[11:8] : eq_index(ufp_lat[3:2], ufp_lat[1:0]);
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            redrive_en    <= 1'b0;
            rx_term_en    <= 1'b0;
            tx_cm_en      <= 1'b0;
            flip_en       <= 1'b0;
            rx_detect_req <= 1'b0;
            dfp_eq_out    <= 4'h0;
            ufp_eq_out    <= 4'h0;
        end else begin
            redrive_en    <= (next_state == rdls_pkg::RDLS_U0);
            rx_term_en    <= (next_state != rdls_pkg::RDLS_DISC);
            tx_cm_en      <= (next_state == rdls_pkg::RDLS_U0) ||
                             (next_state == rdls_pkg::RDLS_U1);
            flip_en       <= cfg_flip;
            // follow the state being entered, so no pulse leaks into U0
            rx_detect_req <= (next_state == rdls_pkg::RDLS_U23 ||
                              next_state == rdls_pkg::RDLS_DISC)
                             && rx_cnt == 32'h0000_0000 && cfg_on && power_good;
            dfp_eq_out    <= lfps ? 4'h0 : dfp_sel;
            ufp_eq_out    <= lfps ? 4'h0 : ufp_sel;
        end
    end
    assign link_state = state;

    // axi4-lite write path: take address and data in either order
    logic        aw_held, w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_go;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_bresp   = 2'b00;
    assign s_axi_rresp   = 2'b00;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go         = aw_held && w_held;
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
        for (int i = 0; i < 4; i++) merge[i*8 +: 8] = st[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    endfunction
    always_ff @(posedge mclk) begin
        if (srst) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            gen_reg      <= `RDLS_GENERAL_RESET;
            eq_reg       <= `RDLS_EQ_RESET;
            idle_reg     <= `RDLS_U2_IDLE_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    `RDLS_GENERAL_OFFSET: gen_reg  <= merge(gen_reg, w_data, w_strb) & 32'h0000_0007;
                    `RDLS_EQ_OFFSET:      eq_reg   <= merge(eq_reg, w_data, w_strb) & 32'h0000_0FFF;
                    `RDLS_U2_IDLE_OFFSET: idle_reg <= merge(idle_reg, w_data, w_strb);
                    default: ;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                case (s_axi_araddr)
                    `RDLS_GENERAL_OFFSET: s_axi_rdata <= gen_reg;
                    `RDLS_EQ_OFFSET:      s_axi_rdata <= eq_reg;
                    `RDLS_STATUS_OFFSET:  s_axi_rdata <= {22'h0, reg_mode, strap_bias_en,
                                                          power_good, cfg_on, cfg_flip,
                                                          1'b0, state};
                    `RDLS_U2_IDLE_OFFSET: s_axi_rdata <= idle_reg;
                    default:              s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ### rdls_top_test.sv
`timescale 1ns/1ps
// bench for the redriver link control block
module rdls_top_test;
    // clock, reset and straps
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic [1:0]  mode_strap = 2'h0;
    logic [3:0]  dfp_eq_inputs = 4'h0;
    logic [3:0]  ufp_eq_inputs = 4'h0;
    logic        superspeed_enable_pin = 1'b0;
    logic        orientation_pin = 1'b0;
    logic        test_strap = 1'b0;
    // partner commands and sensing
    logic        attached = 1'b0;
    logic        idle_cmd = 1'b0;
    logic        lfps_cmd = 1'b0;
    logic        ufp_term_det, dfp_term_det, ufp_elec_idle, dfp_elec_idle, lfps_det;
    // block outputs
    logic        power_good, strap_bias_en, rx_detect_req, redrive_en;
    logic        rx_term_en, tx_cm_en, flip_en;
    logic [3:0]  dfp_eq_out, ufp_eq_out, link_state;
    // axi4-lite master side
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    // responses are always accepted
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    // result counters
    int          miscompares = 0;
    int          total_checks = 0;

    // short counts keep the run brief
    rdls_top #(.PG_CYCLES(20), .HD_CYCLES(4), .DB_CYCLES(8), .RX_PERIOD(8)) i_rdls_top (
        .mclk(mclk), .srst(srst), .mode_strap(mode_strap), .dfp_eq_inputs(dfp_eq_inputs),
        .ufp_eq_inputs(ufp_eq_inputs), .superspeed_enable_pin(superspeed_enable_pin),
        .orientation_pin(orientation_pin), .test_strap(test_strap),
        .ufp_term_det(ufp_term_det), .dfp_term_det(dfp_term_det),
        .ufp_elec_idle(ufp_elec_idle), .dfp_elec_idle(dfp_elec_idle), .lfps_det(lfps_det),
        .power_good(power_good), .strap_bias_en(strap_bias_en),
        .rx_detect_req(rx_detect_req), .redrive_en(redrive_en), .rx_term_en(rx_term_en),
        .tx_cm_en(tx_cm_en), .flip_en(flip_en), .dfp_eq_out(dfp_eq_out),
        .ufp_eq_out(ufp_eq_out), .link_state(link_state),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );
    rdls_link_partner i_rdls_link_partner (.*);

    // 25 ns clock
    always #12.5 mclk = ~mclk;

    // compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic wrap_up();
        if (miscompares == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // reset for 4 cycles, then wait for power good
    task automatic do_reset();
        int n;
        srst <= 1'b1;
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        for (n = 0; n < 40 && power_good !== 1'b1; n++) @(posedge mclk);
        chk({31'h0, power_good}, 32'h1);
        repeat (8) @(posedge mclk);
    endtask
    // wait a bounded time for a link state
    task automatic wait_state(input logic [3:0] exp);
        int n;
        for (n = 0; n < 300 && link_state !== exp; n++) @(posedge mclk);
        chk({28'h0, link_state}, {28'h0, exp});
    endtask
    // axi write: handshakes judged mid-cycle, released after the taking edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (int n = 0; n < 50 && !b; n++) begin
            @(negedge mclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            @(posedge mclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        chk({31'h0, b}, 32'h1);
    endtask
    // axi read: masked data compared from the cycle where rvalid stands
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic ar, r = 1'b0;
        logic [31:0] d;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (int n = 0; n < 50 && !r; n++) begin
            @(negedge mclk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            d = s_axi_rdata;
            @(posedge mclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        chk({31'h0, r}, 32'h1);
        chk(d & m, e);
    endtask

    // every strap pair value maps to its own setting, latched at power good
    task automatic t_eq_straps();
        for (int i = 0; i < 16; i++) begin
            dfp_eq_inputs <= 4'(i);
            ufp_eq_inputs <= 4'(15 - i);
            do_reset();
            chk({28'h0, dfp_eq_out}, 32'(i));
            chk({28'h0, ufp_eq_out}, 32'(15 - i));
            chk({31'h0, strap_bias_en}, 32'h0);
        end
        dfp_eq_inputs <= 4'h0;
        repeat (10) @(posedge mclk);
        chk({28'h0, dfp_eq_out}, 32'hf);
    endtask
    // walk all link states in pin mode
    task automatic t_link_walk();
        axi_wr(8'h34, 32'h0000_0010);
        attached <= 1'b1;
        wait_state(4'h2);
        idle_cmd <= 1'b1;
        wait_state(4'h4);
        chk({30'h0, rx_term_en, tx_cm_en}, 32'h3);
        wait_state(4'h8);
        chk({30'h0, rx_term_en, tx_cm_en}, 32'h2);
        lfps_cmd <= 1'b1;
        idle_cmd <= 1'b0;
        wait_state(4'h2);
        repeat (4) @(posedge mclk);
        chk({28'h0, dfp_eq_out}, 32'h0);
        lfps_cmd <= 1'b0;
        idle_cmd <= 1'b1;
        wait_state(4'h4);
        chk({28'h0, dfp_eq_out}, 32'hf);
        idle_cmd <= 1'b0;
        wait_state(4'h2);
        idle_cmd <= 1'b1;
        wait_state(4'h8);
        attached <= 1'b0;
        wait_state(4'h1);
    endtask
    // debounce, enable pulse sequence and test strap
    task automatic t_enable_pin();
        attached <= 1'b1;
        idle_cmd <= 1'b0;
        wait_state(4'h2);
        superspeed_enable_pin <= 1'b1;
        orientation_pin <= 1'b1;
        repeat (3) @(posedge mclk);
        superspeed_enable_pin <= 1'b0;
        repeat (20) @(posedge mclk);
        chk({27'h0, flip_en, link_state}, 32'h12);
        superspeed_enable_pin <= 1'b1;
        repeat (20) @(posedge mclk);
        chk({31'h0, flip_en}, 32'h1);
        superspeed_enable_pin <= 1'b0;
        wait_state(4'h1);
        chk({31'h0, redrive_en}, 32'h0);
        superspeed_enable_pin <= 1'b1;
        wait_state(4'h2);
        test_strap <= 1'b1;
        wait_state(4'h1);
        test_strap <= 1'b0;
        wait_state(4'h2);
    endtask
    // register mode: reset values, config select and eq fields
    task automatic t_regs();
        superspeed_enable_pin <= 1'b0;
        mode_strap <= 2'h2;
        dfp_eq_inputs <= 4'h5;
        do_reset();
        axi_rd(8'h28, '1, 32'h0000_0001);
        axi_rd(8'h2c, '1, 32'h0000_0000);
        axi_rd(8'h34, '1, 32'h0000_1000);
        axi_rd(8'h3c, '1, 32'h0000_0000);
        axi_rd(8'h30, 32'h0000_0200, 32'h0000_0200);
        chk({28'h0, dfp_eq_out}, 32'h0);
        wait_state(4'h2);
        axi_wr(8'h28, 32'h0000_0000);
        wait_state(4'h1);
        axi_wr(8'h28, 32'h0000_0004);
        repeat (20) @(posedge mclk);
        chk({28'h0, link_state}, 32'h1);
        axi_wr(8'h28, 32'h0000_0005);
        wait_state(4'h2);
        chk({31'h0, flip_en}, 32'h1);
        axi_wr(8'h2c, 32'h0000_0a73);
        repeat (6) @(posedge mclk);
        chk({24'h0, ufp_eq_out, dfp_eq_out}, 32'ha7);
        axi_wr(8'h28, 32'h0000_0001);
        repeat (6) @(posedge mclk);
        chk({27'h0, flip_en, dfp_eq_out}, 32'h3);
    endtask

    // main sequence
    initial begin
        t_eq_straps();
        t_link_walk();
        t_enable_pin();
        t_regs();
        wrap_up();
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        wrap_up();
    end
endmodule
